// >>> sim/fdl_fuse_array_model.sv
// Behavioural fuse array standing behind the loader's cell inputs.
// Assumes the bench presets a factory pattern while reset is held.
`timescale 1ns/1ps

module fdl_fuse_array_model (
  input  wire logic       i_clk,     // System clock
  input  wire logic       i_preset,  // Load factory pattern
  input  wire logic [7:0] i_pattern, // Factory pattern
  input  wire logic [7:0] i_burn,    // Burn select lines
  output logic      [7:0] o_cell     // Cell levels
);
  // Cells only blow outside preset; only the factory preset load can clear a bit
  always_ff @(posedge i_clk) begin
    if (i_preset) begin
      o_cell <= i_pattern;
    end else begin
      o_cell <= o_cell | i_burn;
    end
  end
endmodule

// >>> sim/fdl_loader_asserts.sv
// Checker for the fuse default loader, bound to its ports.
// Assumes fuse cells are steady from reset release until the next burn.
`timescale 1ns/1ps

module fdl_loader_asserts #(
  parameter int FUSE_W = 8,  // Fuse array width
  parameter int ADDR_W = 7   // Register address width
) (
  input wire logic              i_clk,                       // Clock
  input wire logic              i_sys_rst,                   // Reset
  input wire logic [FUSE_W-1:0] i_fuse_cell,                 // Cells
  input wire logic              i_reg_rd,                    // Read
  input wire logic [ADDR_W-1:0] i_reg_addr,                  // Address
  input wire logic              i_burn_req,                  // Burn
  input wire logic              i_factory_trim_en,           // Trim enable
  input wire logic              o_reg_ready,                 // Ready
  input wire logic              o_reg_rvalid,                // Answer
  input wire logic [7:0]        o_reg_rdata,                 // Data
  input wire logic [FUSE_W-1:0] o_fuse_burn,                 // Burn lines
  input wire logic              o_burn_refused,              // Refused
  input wire logic              o_defaults_loaded,           // Loaded
  input wire logic [2:0]        o_dead_time_insertion,       // Dead time
  input wire logic [3:0]        o_high_side_short_threshold, // HS level
  input wire logic [3:0]        o_low_side_short_threshold,  // LS level
  input wire logic [4:0]        o_oscillator_trim            // Trim
);
  // ----
  // Clocking
  // ----
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // Read taking needs ready and no competing burn
  wire rd_taken = o_reg_ready && i_reg_rd && !i_burn_req;

  // ----
  // Assertions
  // ----
  // Count runs 0..10 after release; ready is first seen high at edge 11
  AST_LOAD_TIME: assert property ($fell(i_sys_rst) |-> ##10 !o_reg_ready ##1 o_reg_ready)
    else $error("ready not opened at load end");
  AST_READ_ANSWER: assert property (rd_taken |=> o_reg_rvalid)
    else $error("read got no answer");
  AST_READ_FUSES: assert property (rd_taken && i_reg_addr == 7'h05
    |=> o_reg_rdata == $past(i_fuse_cell))
    else $error("readback differs from cells");
  AST_READ_OTHER: assert property (rd_taken && i_reg_addr != 7'h05 |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_NO_EARLY: assert property (!o_reg_ready |=> !o_reg_rvalid)
    else $error("read answered while closed");
  AST_DEAD_TIME: assert property ($rose(o_defaults_loaded) |-> o_dead_time_insertion ==
    ((i_fuse_cell[7:6] == 2'b00) ? 3'h4 : {1'b0, i_fuse_cell[7:6]}))
    else $error("dead time default wrong");
  AST_SHORT_TRIM: assert property ($rose(o_defaults_loaded) |->
    o_high_side_short_threshold == (i_fuse_cell[5] ? 4'hC : 4'h6) &&
    o_low_side_short_threshold == o_high_side_short_threshold &&
    o_oscillator_trim == i_fuse_cell[4:0])
    else $error("threshold or trim default wrong");
  AST_TRIM_GUARD: assert property (o_reg_ready && i_burn_req && !i_factory_trim_en
    |=> o_fuse_burn[4:0] == 5'h00)
    else $error("trim burned without enable");
  AST_BURN_OR_REFUSE: assert property (o_reg_ready && i_burn_req
    |=> (o_fuse_burn != 8'h00) != o_burn_refused)
    else $error("burn and refusal not exclusive");
  AST_THR_RANGE: assert property (o_defaults_loaded |-> o_low_side_short_threshold >= 4'h1
    && o_high_side_short_threshold >= 4'h2)
    else $error("threshold below minimum");
  AST_ONCE: assert property (o_defaults_loaded |=> o_defaults_loaded
    && $stable(o_dead_time_insertion) && $stable(o_oscillator_trim))
    else $error("defaults reloaded after power-up");
  // Select lines stand 200 samples, then drop and access reopens
  AST_BURN_TIME: assert property ($rose(|o_fuse_burn) |-> ##199 (|o_fuse_burn)
    ##1 (!(|o_fuse_burn) && o_reg_ready))
    else $error("burn pulse length wrong");

  // Main scenarios reached
  COV_READ: cover property (rd_taken ##1 o_reg_rvalid);
  COV_BURN: cover property (o_fuse_burn != 8'h00);
  COV_REFUSE: cover property (o_burn_refused);
endmodule

bind fdl_loader fdl_loader_asserts #(.FUSE_W(FUSE_W), .ADDR_W(ADDR_W)) i_fdl_loader_asserts (
  .i_clk, .i_sys_rst, .i_fuse_cell, .i_reg_rd, .i_reg_addr, .i_burn_req,
  .i_factory_trim_en, .o_reg_ready, .o_reg_rvalid, .o_reg_rdata, .o_fuse_burn,
  .o_burn_refused, .o_defaults_loaded, .o_dead_time_insertion,
  .o_high_side_short_threshold, .o_low_side_short_threshold, .o_oscillator_trim);

// >>> sim/test_fuse_default_loader.sv
// Testbench of the fuse default loader with a fuse array model.
// Assumes the loader and its package are compiled first.
`timescale 1ns/1ps

module test_fuse_default_loader;
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        i_reg_rd = 1'b0;
  logic [6:0]  i_reg_addr = 7'h00;
  logic        i_burn_req = 1'b0;
  logic [7:0]  i_burn_bits = 8'h00;
  logic        i_factory_trim_en = 1'b0;
  logic        i_thr_wr = 1'b0;
  logic [3:0]  i_hs_thr = 4'h0;
  logic [3:0]  i_ls_thr = 4'h0;
  logic        preset = 1'b1;
  logic [7:0]  pattern = 8'h00;
  logic [7:0]  i_fuse_cell, o_reg_rdata, o_fuse_burn;
  logic        o_reg_ready, o_reg_rvalid, o_burn_refused, o_defaults_loaded;
  logic [2:0]  o_dead_time_insertion;
  logic [3:0]  o_high_side_short_threshold, o_low_side_short_threshold;
  logic [4:0]  o_oscillator_trim;
  logic [31:0] seed = 32'h0000_753A;
  int          fails = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  fdl_loader i_fdl_loader (.i_clk, .i_sys_rst, .i_fuse_cell, .i_reg_rd, .i_reg_addr,
    .i_burn_req, .i_burn_bits, .i_factory_trim_en, .i_thr_wr, .i_hs_thr, .i_ls_thr,
    .o_reg_ready, .o_reg_rvalid, .o_reg_rdata, .o_fuse_burn, .o_burn_refused,
    .o_defaults_loaded, .o_dead_time_insertion, .o_high_side_short_threshold,
    .o_low_side_short_threshold, .o_oscillator_trim);
  fdl_fuse_array_model i_fdl_fuse_array_model (.i_clk, .i_preset(preset),
    .i_pattern(pattern), .i_burn(o_fuse_burn), .o_cell(i_fuse_cell));

  // Clock and hang guard; a stuck handshake would otherwise run forever
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 8000) begin
      fails++;
      give_verdict();
    end
  end

  // ----
  // Helpers
  // ----
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [3:0] clamp(input logic [3:0] v, input logic [3:0] lo);
    return (v < lo) ? lo : v;
  endfunction
  function automatic logic [7:0] mask(input logic [7:0] b, f, input logic en);
    return b & ~f & (en ? 8'hFF : 8'hE0);
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (o_reg_ready !== 1'b1 && n < 400) begin
      @(negedge i_clk);
      n++;
    end
    chk("ready in time", 8'h01, {7'h00, n < 400});
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp, input logic ans);
    @(negedge i_clk);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    // Answer sampled mid-period, clear of the edge that switches it
    @(negedge i_clk);
    i_reg_rd = 1'b0;
    chk("rvalid", {7'h00, ans}, {7'h00, o_reg_rvalid});
    if (ans) chk("rdata", exp, o_reg_rdata);
  endtask
  task automatic burn(input logic [7:0] b, m);
    @(negedge i_clk);
    i_burn_bits = b;
    i_burn_req = 1'b1;
    @(negedge i_clk);
    i_burn_req = 1'b0;
    chk("burn lines", m, o_fuse_burn);
    chk("refused", {7'h00, m == 8'h00}, {7'h00, o_burn_refused});
  endtask
  task automatic powerup(input logic [7:0] f);
    i_sys_rst = 1'b1;
    preset = 1'b1;
    pattern = f;
    repeat (16) @(negedge i_clk);
    chk("ready in reset", 8'h00, {7'h00, o_reg_ready});
    chk("loaded in reset", 8'h00, {7'h00, o_defaults_loaded});
    preset = 1'b0;
    i_sys_rst = 1'b0;
    wait_ready();
    chk("loaded", 8'h01, {7'h00, o_defaults_loaded});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----
  // Main sequence: power-ups over every dead time code, then burns
  // ----
  initial begin
    logic [7:0] f;
    logic [7:0] m;
    logic [3:0] h;
    logic [3:0] l;
    for (int k = 0; k < 6; k++) begin
      f = (k == 0) ? 8'h00 : (k == 5) ? 8'hFF : 8'(rnd());
      if (k > 0 && k < 5) f[7:6] = 2'(k);
      powerup(f);
      chk("dead time", (f[7:6] == 2'b00) ? 8'h04 : {6'h00, f[7:6]},
        {5'h00, o_dead_time_insertion});
      chk("hs level", f[5] ? 8'h0C : 8'h06, {4'h0, o_high_side_short_threshold});
      chk("ls level", f[5] ? 8'h0C : 8'h06, {4'h0, o_low_side_short_threshold});
      chk("trim", {3'h0, f[4:0]}, {3'h0, o_oscillator_trim});
      // Reference read taken while no select line is driven
      rd(7'h05, f, 1'b1);
      rd(7'h40 | 7'(rnd()), 8'h00, 1'b1);
      h = (k == 0) ? 4'h0 : 4'(rnd());
      l = (k == 0) ? 4'h0 : 4'(rnd());
      @(negedge i_clk);
      {i_thr_wr, i_hs_thr, i_ls_thr} = {1'b1, h, l};
      @(negedge i_clk);
      i_thr_wr = 1'b0;
      chk("hs write", {4'h0, clamp(h, 4'h2)}, {4'h0, o_high_side_short_threshold});
      chk("ls write", {4'h0, clamp(l, 4'h1)}, {4'h0, o_low_side_short_threshold});
      $display("power-up test %0d done", k);
    end
    f = 8'h21;
    powerup(f);
    m = mask(8'hFF, f, 1'b0);
    burn(8'hFF, m);
    rd(7'h05, 8'h00, 1'b0);
    wait_ready();
    f = f | m;
    rd(7'h05, f, 1'b1);
    chk("dead time kept", 8'h04, {5'h00, o_dead_time_insertion});
    burn(8'h80, mask(8'h80, f, 1'b0));
    i_factory_trim_en = 1'b1;
    m = mask(8'h02, f, 1'b1);
    burn(8'h02, m);
    wait_ready();
    rd(7'h05, f | m, 1'b1);
    $display("burn test done");
    give_verdict();
  end
endmodule

// >>> verilog/fdl_fuse_bit.sv
// One fuse cell sense path: two-stage synchroniser and a sticky copy.
// Assumes the cell level is static apart from burning, from another domain.
`timescale 1ns/1ps

module fdl_fuse_bit (
  input  wire logic i_clk,      // System clock
  input  wire logic i_sys_rst,  // Synchronous reset, high
  input  wire logic i_cell,     // Raw fuse cell level
  output logic      o_value     // Sensed, falls back only on reset
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic keep;
  } fdl_bit_s;

  fdl_bit_s st;
  fdl_bit_s next_st;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Sticky OR hides sense glitches: a blown fuse reads zero again only after a reset, until resensed
  always_comb begin
    next_st       = st;
    next_st.sync1 = i_cell;
    next_st.sync2 = st.sync1;
    next_st.keep  = st.keep | st.sync2;
  end

  // Register the state copy
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_value = st.keep;

endmodule

// >>> verilog/fdl_loader.sv
// Fuse default loader: senses the fuse array, applies reset defaults for
// dead time, short thresholds and oscillator trim, serves the readback
// register and sequences burns. Assumes the serial register front end
// presents single-cycle read strobes and the fuse array burns while a
// select line is held high.
//
// Behaviour
// - At power-up, dead time, thresholds and trim defaults come from fuses.
// - Unprogrammed fuse bits read as zero.
// - Programming only sets fuse bits; nothing clears a programmed bit.
// - Fuses read as 8-bit read-only register at 0x05, bit n at n.
// - Fuse bits 7:6 give dead time; code 0 is 4 clocks, else code.
// - Fuse bit 5 selects both short thresholds: 6 when zero, 12 when one.
// - Fuse bits 4:0 give oscillator trim, 0 slowest, 31 fastest.
// - Trim fuses are factory set; host should not burn them further.
// - Low-side threshold accepts 1..15, high-side 2..15; higher is less sensitive.
`timescale 1ns/1ps

module fdl_loader #(
  parameter int FUSE_W = fdl_pkg::FUSE_W,  // Fuse array width
  parameter int ADDR_W = fdl_pkg::ADDR_W   // Register address width
) (
  input  wire logic              i_clk,                       // System clock
  input  wire logic              i_sys_rst,                   // Sync reset, high
  input  wire logic [FUSE_W-1:0] i_fuse_cell,                 // Raw fuse levels
  input  wire logic              i_reg_rd,                    // Read strobe
  input  wire logic [ADDR_W-1:0] i_reg_addr,                  // Read address
  input  wire logic              i_burn_req,                  // Burn request strobe
  input  wire logic [FUSE_W-1:0] i_burn_bits,                 // Bits to set
  input  wire logic              i_factory_trim_en,           // Trim burn allowed
  input  wire logic              i_thr_wr,                    // Threshold write
  input  wire logic [3:0]        i_hs_thr,                    // High-side level
  input  wire logic [3:0]        i_ls_thr,                    // Low-side level
  output logic                   o_reg_ready,                 // Access open
  output logic                   o_reg_rvalid,                // Read answer
  output logic [7:0]             o_reg_rdata,                 // Read data
  output logic [FUSE_W-1:0]      o_fuse_burn,                 // Burn select lines
  output logic                   o_burn_refused,              // Nothing to burn
  output logic                   o_defaults_loaded,           // Defaults applied
  output logic [2:0]             o_dead_time_insertion,       // Dead time clocks
  output logic [3:0]             o_high_side_short_threshold, // HS short level
  output logic [3:0]             o_low_side_short_threshold,  // LS short level
  output logic [4:0]             o_oscillator_trim            // Clock trim
);

  // ----------------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------------
  typedef struct packed {
    fdl_pkg::fdl_state_e state;
    logic [7:0]          count;
    logic                loaded;
    logic                ready;
    logic                rvalid;
    logic [7:0]          rdata;
    logic [FUSE_W-1:0]   burn;
    logic                refused;
    logic [2:0]          dead_time;
    logic [3:0]          hs_thr;
    logic [3:0]          ls_thr;
    logic [4:0]          trim;
  } fdl_loader_s;

  fdl_loader_s st;
  fdl_loader_s next_st;

  logic [FUSE_W-1:0] fuse_sensed;
  logic [1:0]        fuse_deadtime_default;
  logic              fuse_short_threshold_default;
  logic [4:0]        fuse_clock_trim_default;
  logic [FUSE_W-1:0] burn_mask;
  logic [FUSE_W-1:0] readback;

  // ----------------------------------------------------------------------
  // Fuse sense paths, one per cell
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < FUSE_W; gi = gi + 1) begin : g_cell
      fdl_fuse_bit u_bit (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_cell    (i_fuse_cell[gi]),
        .o_value   (fuse_sensed[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Field split of the sensed fuses
  // ----------------------------------------------------------------------
  // Field slices of the sensed array
  assign fuse_deadtime_default        =
    fuse_sensed[fdl_pkg::DEADTIME_MSB:fdl_pkg::DEADTIME_LSB];
  assign fuse_short_threshold_default = fuse_sensed[fdl_pkg::SHORT_LEVEL_BIT];
  assign fuse_clock_trim_default      =
    fuse_sensed[fdl_pkg::TRIM_MSB:fdl_pkg::TRIM_LSB];

  // Readback low-bit aligned, wider arrays cut to the register width
  always_comb begin
    readback = fuse_sensed;
  end

  // Burn only cells still blank; trim cells need the factory enable
  always_comb begin
    burn_mask = i_burn_bits & ~fuse_sensed;
    if (!i_factory_trim_en) begin
      burn_mask = burn_mask & ~FUSE_W'(fdl_pkg::TRIM_FIELD_MASK);
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Sequencer, register read and threshold update
  always_comb begin
    next_st         = st;
    next_st.rvalid  = 1'b0;
    next_st.refused = 1'b0;
    case (st.state)
      // Wait for synchronisers and fuse sense to settle, then apply once
      fdl_pkg::FDL_LOAD: begin
        if (st.count == fdl_pkg::SETTLE_CYCLES) begin
          next_st.state  = fdl_pkg::FDL_READY;
          next_st.count  = fdl_pkg::COUNT_RESET;
          next_st.loaded = 1'b1;
          next_st.ready  = 1'b1;
          if (fuse_deadtime_default == 2'b00) begin
            next_st.dead_time = fdl_pkg::DEADTIME_CODE0_CLK;
          end else begin
            next_st.dead_time = {1'b0, fuse_deadtime_default};
          end
          if (fuse_short_threshold_default) begin
            next_st.hs_thr = fdl_pkg::SHORT_LEVEL_HIGH;
            next_st.ls_thr = fdl_pkg::SHORT_LEVEL_HIGH;
          end else begin
            next_st.hs_thr = fdl_pkg::SHORT_LEVEL_LOW;
            next_st.ls_thr = fdl_pkg::SHORT_LEVEL_LOW;
          end
          next_st.trim = fuse_clock_trim_default;
        end else begin
          next_st.count = st.count + 8'h01;
        end
      end
      // Host access open; burn takes priority over read and write
      fdl_pkg::FDL_READY: begin
        if (i_burn_req) begin
          if (burn_mask != '0) begin
            next_st.state = fdl_pkg::FDL_BURN;
            next_st.burn  = burn_mask;
            next_st.count = fdl_pkg::COUNT_RESET;
            next_st.ready = 1'b0;
          end else begin
            next_st.refused = 1'b1;
          end
        end else begin
          if (i_reg_rd) begin
            next_st.rvalid = 1'b1;
            if (i_reg_addr == ADDR_W'(fdl_pkg::FUSE_READBACK_ADDR)) begin
              next_st.rdata = readback[7:0];
            end else begin
              next_st.rdata = fdl_pkg::RDATA_RESET;
            end
          end
          // Out-of-range settings are clamped to the nearest legal level
          if (i_thr_wr) begin
            if (i_hs_thr < fdl_pkg::HS_THR_MIN) begin
              next_st.hs_thr = fdl_pkg::HS_THR_MIN;
            end else begin
              next_st.hs_thr = i_hs_thr;
            end
            if (i_ls_thr < fdl_pkg::LS_THR_MIN) begin
              next_st.ls_thr = fdl_pkg::LS_THR_MIN;
            end else begin
              next_st.ls_thr = i_ls_thr;
            end
          end
        end
      end
      // Hold select lines for the burn time; defaults are not reloaded
      fdl_pkg::FDL_BURN: begin
        if (st.count == fdl_pkg::BURN_CYCLES - 8'h01) begin
          next_st.state = fdl_pkg::FDL_READY;
          next_st.burn  = '0;
          next_st.count = fdl_pkg::COUNT_RESET;
          next_st.ready = 1'b1;
        end else begin
          next_st.count = st.count + 8'h01;
        end
      end
      default: begin
        next_st.state = fdl_pkg::FDL_LOAD;
        next_st.count = fdl_pkg::COUNT_RESET;
        next_st.ready = 1'b0;
        next_st.burn  = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Reset values hold until the fuses have been sensed
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st.state     <= fdl_pkg::FDL_LOAD;
      st.count     <= fdl_pkg::COUNT_RESET;
      st.loaded    <= 1'b0;
      st.ready     <= 1'b0;
      st.rvalid    <= 1'b0;
      st.rdata     <= fdl_pkg::RDATA_RESET;
      st.burn      <= '0;
      st.refused   <= 1'b0;
      st.dead_time <= fdl_pkg::DEADTIME_RESET;
      st.hs_thr    <= fdl_pkg::THR_RESET;
      st.ls_thr    <= fdl_pkg::THR_RESET;
      st.trim      <= fdl_pkg::TRIM_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------------
  assign o_reg_ready                 = st.ready;
  assign o_reg_rvalid                = st.rvalid;
  assign o_reg_rdata                 = st.rdata;
  assign o_fuse_burn                 = st.burn;
  assign o_burn_refused              = st.refused;
  assign o_defaults_loaded           = st.loaded;
  assign o_dead_time_insertion       = st.dead_time;
  assign o_high_side_short_threshold = st.hs_thr;
  assign o_low_side_short_threshold  = st.ls_thr;
  assign o_oscillator_trim           = st.trim;

endmodule

// >>> verilog/fdl_pkg.sv
// Package of the fuse default loader: register map, fuse field layout,
// default values, states and timing counts.
// Assumes a 100 MHz system clock; all users refer to names as fdl_pkg::name.
package fdl_pkg;

  // ----------------------------------------------------------------------
  // Register map and widths
  // ----------------------------------------------------------------------
  localparam int              ADDR_W             = 7;
  localparam int              FUSE_W             = 8;
  localparam logic [6:0]      FUSE_READBACK_ADDR = 7'h05;
  localparam logic [7:0]      FUSE_RESET         = 8'h00;  // Unprogrammed fuses read zero
  localparam logic [7:0]      RDATA_RESET        = 8'h00;

  // ----------------------------------------------------------------------
  // Fuse field layout
  // ----------------------------------------------------------------------
  localparam int              DEADTIME_MSB       = 7;
  localparam int              DEADTIME_LSB       = 6;
  localparam int              SHORT_LEVEL_BIT    = 5;
  localparam int              TRIM_MSB           = 4;
  localparam int              TRIM_LSB           = 0;
  localparam logic [7:0]      TRIM_FIELD_MASK    = 8'h1F;

  // ----------------------------------------------------------------------
  // Default values derived from the fuses
  // ----------------------------------------------------------------------
  localparam logic [2:0]      DEADTIME_CODE0_CLK = 3'h4;   // Code 0 means four clocks
  localparam logic [2:0]      DEADTIME_RESET     = 3'h4;
  localparam logic [3:0]      SHORT_LEVEL_LOW    = 4'h6;
  localparam logic [3:0]      SHORT_LEVEL_HIGH   = 4'hC;
  localparam logic [3:0]      LS_THR_MIN         = 4'h1;
  localparam logic [3:0]      HS_THR_MIN         = 4'h2;
  localparam logic [3:0]      THR_RESET          = 4'h6;
  localparam logic [4:0]      TRIM_RESET         = 5'h00;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int              CLK_PERIOD_NS      = 10;
  localparam int              SENSE_SETTLE_NS    = 100;    // Fuse sense settling, least
  localparam int              BURN_TIME_NS       = 2000;   // Burn pulse width, least
  localparam logic [7:0]      SETTLE_CYCLES      =
    8'((SENSE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0]      BURN_CYCLES        =
    8'((BURN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0]      COUNT_RESET        = 8'h00;

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FDL_LOAD  = 2'b00,   // Sensing fuses after reset
    FDL_READY = 2'b01,   // Defaults applied, host access open
    FDL_BURN  = 2'b10    // Burn pulse on the fuse array
  } fdl_state_e;

endpackage
